// ==== src/mfpm_top.sv ====
/*
 * multifunction port mux: mux registers for ports 0, 1, 2 plus the port 2 pull-up / adc trigger register,
 * and the pin routing they steer.
 * assumes a simple byte register port on the system clock (write strobe, read strobe, address, data),
 * that pin-side signals here are already on the system clock, and that pads resolve enables elsewhere.
 */
`timescale 1ns/1ps
`include "mfpm_defines.svh"

module mfpm_top (
	input  wire logic       CLK_I,
	input  wire logic       RST_I,
	input  wire logic [7:0] ADDR_I,
	input  wire logic       INDIRECT_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	input  wire logic [7:0] WDATA_I,
	output logic      [7:0] RDATA_O,
	input  wire logic       DEBUG_DISABLE_I,
	input  wire logic       OPTION_LOAD_I,
	input  wire logic [7:0] PORT2_MUX_OPTION_BYTE_I,
	input  wire logic       ADC_CONV_START_I,
	input  wire logic       ADC_STOP_I,
	output logic            ADC_HW_TRIGGER_ENABLE_O,
	output logic [2:0]      PORT0_LOW_ROUTE_O,
	output logic [2:0]      PORT0_MID_ROUTE_O,
	output logic [2:0]      PORT0_HIGH_ROUTE_O,
	output logic [5:0]      PORT1_PWM_SEL_O,
	input  wire logic [5:0] IO_BANK_ONE_OUT_I,
	input  wire logic [5:0] IO_BANK_ONE_OE_I,
	input  wire logic [5:0] PWM_I,
	output logic [5:0]      PORT1_PIN_OUT_O,
	output logic [5:0]      PORT1_PIN_OE_O,
	output logic            PORT2_PIN1_FAST_O,
	output logic            PORT2_PIN3_FAST_O,
	output logic [1:0]      PORT2_UPPER_PAIR_MODE_O,
	output logic            DEBUG_PIN_GPIO_O,
	output logic            DEBUG_PIN_FAST_O,
	output logic [5:0]      PORT2_PULLUP_EN_O
);

	mfpm_pkg::mfpm_state_t state;
	mfpm_pkg::mfpm_state_t next_state;
	mfpm_pkg::mfpm_p0_route_t route_low;
	mfpm_pkg::mfpm_p0_route_t route_mid;
	mfpm_pkg::mfpm_p0_route_t route_high;
	logic                  debug_gpio;
	logic                  debug_fast;

	// masked write: reserved bits are forced to zero so they always read zero
	function automatic logic [7:0] mfpm_wmask(input logic [7:0] data, input logic [7:0] mask);
		mfpm_wmask = data & mask;
	endfunction

	// address match in the direct or indirect area
	function automatic logic mfpm_hit(input logic [7:0] addr, input logic ind, input logic [7:0] ofs,
	                                  input logic want_ind);
		mfpm_hit = (addr == ofs) && (ind == want_ind);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next-state: register writes, option load, hardware clear of the trigger enable
	always_comb begin
		next_state = state;
		if (OPTION_LOAD_I) begin
			// option byte carries one bit for the upper pair, so bit 5 is forced low
			next_state.p2 = mfpm_wmask(PORT2_MUX_OPTION_BYTE_I, `MFPM_MASK_P2 & 8'hdf);
		end
		if (WR_I) begin
			if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT0_MUX_CONTROL, 1'b0)) begin
				next_state.p0 = mfpm_wmask(WDATA_I, `MFPM_MASK_P0);
			end
			if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT1_MUX_CONTROL, 1'b0)) begin
				next_state.p1 = mfpm_wmask(WDATA_I, `MFPM_MASK_P1);
			end
			if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT2_MUX_CONTROL, 1'b1)) begin
				next_state.p2 = mfpm_wmask(WDATA_I, `MFPM_MASK_P2);
			end
			if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT2_PULLUP_AND_ADC_TRIGGER, 1'b1)) begin
				next_state.aux = mfpm_wmask(WDATA_I, `MFPM_MASK_AUX);
			end
		end
		// hardware clear wins over a software set in the same cycle: a start must disarm
		if (ADC_CONV_START_I || ADC_STOP_I) begin
			next_state.aux[`MFPM_ADC_TRIG_BIT] = 1'b0;
		end
		// read data registered; unmapped addresses read zero
		next_state.rdata = 8'h00;
		if (RD_I) begin
			if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT0_MUX_CONTROL, 1'b0)) begin
				next_state.rdata = state.p0;
			end else if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT1_MUX_CONTROL, 1'b0)) begin
				next_state.rdata = state.p1;
			end else if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT2_MUX_CONTROL, 1'b1)) begin
				next_state.rdata = state.p2;
			end else if (mfpm_hit(ADDR_I, INDIRECT_I, `MFPM_OFS_PORT2_PULLUP_AND_ADC_TRIGGER, 1'b1)) begin
				next_state.rdata = state.aux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			state.aux   <= `MFPM_RST_AUX;
			state.p2    <= `MFPM_RST_P2 & `MFPM_MASK_P2;
			state.p0    <= `MFPM_RST_P0;
			state.p1    <= `MFPM_RST_P1;
			state.rdata <= 8'h00;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// port 0 pair decoders
	mfpm_pair_route u_low (
		.PAIR_I  (2'd0),
		.CODE_I  (state.p0[1:0]),
		.ROUTE_O (route_low)
	);
	mfpm_pair_route u_mid (
		.PAIR_I  (2'd1),
		.CODE_I  (state.p0[3:2]),
		.ROUTE_O (route_mid)
	);
	mfpm_pair_route u_high (
		.PAIR_I  (2'd2),
		.CODE_I  (state.p0[5:4]),
		.ROUTE_O (route_high)
	);

	// gpio code on the low pair also covers the comparator reference; pad setup is software's job
	assign PORT0_LOW_ROUTE_O  = route_low;
	assign PORT0_MID_ROUTE_O  = route_mid;
	assign PORT0_HIGH_ROUTE_O = route_high;

	////////////////////////////////////////////////////////////////////////////////
	// port 1: per-pin gpio or pwm; pwm drives the pad whenever selected
	assign PORT1_PWM_SEL_O = state.p1[5:0];
	always_comb begin
		for (int n = 0; n < 6; n++) begin
			PORT1_PIN_OUT_O[n] = state.p1[n] ? PWM_I[n] : IO_BANK_ONE_OUT_I[n];
			PORT1_PIN_OE_O[n]  = state.p1[n] ? 1'b1 : IO_BANK_ONE_OE_I[n];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// port 2 selects
	assign PORT2_PIN1_FAST_O       = state.p2[`MFPM_P2_PIN1_BIT];
	assign PORT2_PIN3_FAST_O       = state.p2[`MFPM_P2_PIN3_BIT];
	assign PORT2_UPPER_PAIR_MODE_O = state.p2[5:`MFPM_P2_PAIR_LO_BIT];

	// debug pin: select acts only when the debug function is disabled globally
	assign debug_gpio = DEBUG_DISABLE_I && !state.p2[`MFPM_DBG_SEL_BIT];
	assign debug_fast = DEBUG_DISABLE_I && state.p2[`MFPM_DBG_SEL_BIT];
	assign DEBUG_PIN_GPIO_O = debug_gpio;
	assign DEBUG_PIN_FAST_O = debug_fast;

	////////////////////////////////////////////////////////////////////////////////
	// pull-ups: a 0 bit enables; fast input 1 on the debug pin is always pulled up
	always_comb begin
		PORT2_PULLUP_EN_O    = ~state.aux[5:0];
		PORT2_PULLUP_EN_O[1] = ~state.aux[1] | debug_fast;
	end

	assign ADC_HW_TRIGGER_ENABLE_O = state.aux[`MFPM_ADC_TRIG_BIT];
	assign RDATA_O                 = state.rdata;

endmodule // mfpm_top

// ==== include/mfpm_defines.svh ====
/*
 * register offsets, reset values, field positions and codes for the multifunction port mux.
 * assumes inclusion by bare name from the design files.
 */
`ifndef MFPM_DEFINES_SVH
`define MFPM_DEFINES_SVH

// register offsets (direct area for ports 0/1, indirect area for port 2 and aux)
`define MFPM_OFS_PORT2_PULLUP_AND_ADC_TRIGGER 8'h08
`define MFPM_OFS_PORT2_MUX_CONTROL            8'h13
`define MFPM_OFS_PORT0_MUX_CONTROL            8'h2a
`define MFPM_OFS_PORT1_MUX_CONTROL            8'h2b

// reset values
`define MFPM_RST_AUX  8'h00
`define MFPM_RST_P2   8'hff
`define MFPM_RST_P0   8'h00
`define MFPM_RST_P1   8'h3f

// writable bit masks; reserved bits stay zero
`define MFPM_MASK_AUX 8'hbf
`define MFPM_MASK_P2  8'hba
`define MFPM_MASK_P0  8'h3f
`define MFPM_MASK_P1  8'h3f

// field positions
`define MFPM_ADC_TRIG_BIT   7
`define MFPM_DBG_SEL_BIT    7
`define MFPM_P2_PIN1_BIT    1
`define MFPM_P2_PIN3_BIT    3
`define MFPM_P2_PAIR_LO_BIT 4

// 2-bit pair codes
`define MFPM_CODE_00 2'h0
`define MFPM_CODE_01 2'h1
`define MFPM_CODE_10 2'h2
`define MFPM_CODE_11 2'h3

`endif

// ==== include/mfpm_pkg.sv ====
/*
 * types for the multifunction port mux.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mfpm_pkg;

	// routing chosen for a port 0 pin pair
	typedef enum logic [2:0] {
		MFPM_P0_GPIO   = 3'h0,
		MFPM_P0_UART   = 3'h1,
		MFPM_P0_I2C    = 3'h3,
		MFPM_P0_OSC    = 3'h2,
		MFPM_P0_LIGHT  = 3'h6,
		MFPM_P0_CMPREF = 3'h7,
		MFPM_P0_NONE   = 3'h5
	} mfpm_p0_route_t;

	// whole register state of the block
	typedef struct packed {
		logic [7:0] aux;
		logic [7:0] p2;
		logic [7:0] p0;
		logic [7:0] p1;
		logic [7:0] rdata;
	} mfpm_state_t;

endpackage

// ==== src/mfpm_pair_route.sv ====
/*
 * decodes one port 0 pin-pair select code into a route for that pair.
 * assumes the caller passes the pair index (0 low, 1 mid, 2 high) as a constant.
 */
`timescale 1ns/1ps
`include "mfpm_defines.svh"

module mfpm_pair_route (
	input  wire logic [1:0]             PAIR_I,
	input  wire logic [1:0]             CODE_I,
	output mfpm_pkg::mfpm_p0_route_t    ROUTE_O
);

	////////////////////////////////////////////////////////////////////////////////
	// purely combinational; the code comes from a register, so the route changes only after a clock edge
	always_comb begin
		ROUTE_O = mfpm_pkg::MFPM_P0_GPIO;
		case (PAIR_I)
			2'd0: begin
				case (CODE_I)
					`MFPM_CODE_01: ROUTE_O = mfpm_pkg::MFPM_P0_UART;
					`MFPM_CODE_10: ROUTE_O = mfpm_pkg::MFPM_P0_I2C;
					`MFPM_CODE_11: ROUTE_O = mfpm_pkg::MFPM_P0_NONE; // reserved code drives nothing
					default:       ROUTE_O = mfpm_pkg::MFPM_P0_GPIO;
				endcase
			end
			2'd1: begin
				case (CODE_I)
					`MFPM_CODE_01: ROUTE_O = mfpm_pkg::MFPM_P0_I2C;
					`MFPM_CODE_10: ROUTE_O = mfpm_pkg::MFPM_P0_OSC;
					`MFPM_CODE_11: ROUTE_O = mfpm_pkg::MFPM_P0_UART;
					default:       ROUTE_O = mfpm_pkg::MFPM_P0_GPIO;
				endcase
			end
			default: begin
				case (CODE_I)
					`MFPM_CODE_01: ROUTE_O = mfpm_pkg::MFPM_P0_LIGHT;
					`MFPM_CODE_10: ROUTE_O = mfpm_pkg::MFPM_P0_I2C;
					`MFPM_CODE_11: ROUTE_O = mfpm_pkg::MFPM_P0_UART;
					default:       ROUTE_O = mfpm_pkg::MFPM_P0_GPIO;
				endcase
			end
		endcase
	end

endmodule // mfpm_pair_route

// ==== sim/mfpm_monitor.sv ====
/* checker for the port mux: routing and register relations at the top ports.
   assumes a bind onto mfpm_top, ports matched by name. */
`timescale 1ns/1ps
module mfpm_monitor (
	input wire logic       CLK_I,
	input wire logic       RST_I,
	input wire logic       WR_I,
	input wire logic       RD_I,
	input wire logic       INDIRECT_I,
	input wire logic       DEBUG_DISABLE_I,
	input wire logic       ADC_CONV_START_I,
	input wire logic       ADC_STOP_I,
	input wire logic       ADC_HW_TRIGGER_ENABLE_O,
	input wire logic       DEBUG_PIN_GPIO_O,
	input wire logic       DEBUG_PIN_FAST_O,
	input wire logic       PORT2_PIN1_FAST_O,
	input wire logic       PORT2_PIN3_FAST_O,
	input wire logic [1:0] PORT2_UPPER_PAIR_MODE_O,
	input wire logic [2:0] PORT0_LOW_ROUTE_O,
	input wire logic [2:0] PORT0_MID_ROUTE_O,
	input wire logic [2:0] PORT0_HIGH_ROUTE_O,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic [7:0] RDATA_O,
	input wire logic [5:0] PWM_I,
	input wire logic [5:0] IO_BANK_ONE_OUT_I,
	input wire logic [5:0] IO_BANK_ONE_OE_I,
	input wire logic [5:0] PORT1_PWM_SEL_O,
	input wire logic [5:0] PORT1_PIN_OUT_O,
	input wire logic [5:0] PORT1_PIN_OE_O,
	input wire logic [5:0] PORT2_PULLUP_EN_O
);
	// route per 2-bit pair code; low pair code 11 has no route
	localparam logic [2:0] LT [4] = '{3'h0, 3'h1, 3'h3, 3'h5};
	localparam logic [2:0] MT [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
	localparam logic [2:0] HT [4] = '{3'h0, 3'h6, 3'h3, 3'h1};
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	//////////////////////////////
	// an access taken at this edge; aux write only counts without a clearing pulse
	sequence s_acc(s, a, i);
		s && ADDR_I == a && INDIRECT_I == i;
	endsequence
	sequence s_aux_wr;
		s_acc(WR_I, 8'h08, 1'b1) ##0 (!ADC_CONV_START_I && !ADC_STOP_I);
	endsequence
	property p_p0;
		s_acc(WR_I, 8'h2a, 1'b0) |=> PORT0_LOW_ROUTE_O == LT[$past(WDATA_I[1:0])]
			&& PORT0_MID_ROUTE_O == MT[$past(WDATA_I[3:2])] && PORT0_HIGH_ROUTE_O == HT[$past(WDATA_I[5:4])];
	endproperty
	a_p0: assert property (p_p0) else $error("port 0 route");
	property p_p2;
		s_acc(WR_I, 8'h13, 1'b1) |=> {PORT2_UPPER_PAIR_MODE_O, PORT2_PIN3_FAST_O, PORT2_PIN1_FAST_O}
			== {$past(WDATA_I[5:3]), $past(WDATA_I[1])};
	endproperty
	a_p2: assert property (p_p2) else $error("port 2 route");
	property p_aux;
		s_aux_wr |=> {ADC_HW_TRIGGER_ENABLE_O, PORT2_PULLUP_EN_O[5:2], PORT2_PULLUP_EN_O[0]}
			== {$past(WDATA_I[7]), ~$past(WDATA_I[5:2]), ~$past(WDATA_I[0])};
	endproperty
	a_aux: assert property (p_aux) else $error("aux write");
	property p_clr;
		ADC_CONV_START_I || ADC_STOP_I |=> !ADC_HW_TRIGGER_ENABLE_O;
	endproperty
	a_clr: assert property (p_clr) else $error("trigger enable not cleared");
	property p_rst;
		$fell(RST_I) |-> !ADC_HW_TRIGGER_ENABLE_O && PORT2_PULLUP_EN_O == 6'h3f && PORT1_PWM_SEL_O == 6'h3f
			&& {PORT2_UPPER_PAIR_MODE_O, PORT2_PIN3_FAST_O, PORT2_PIN1_FAST_O} == 4'hf
			&& PORT0_LOW_ROUTE_O == 3'h0 && PORT0_MID_ROUTE_O == 3'h0 && PORT0_HIGH_ROUTE_O == 3'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_p1;
		PORT1_PIN_OUT_O == (PWM_I & PORT1_PWM_SEL_O | IO_BANK_ONE_OUT_I & ~PORT1_PWM_SEL_O)
			&& PORT1_PIN_OE_O == (PORT1_PWM_SEL_O | IO_BANK_ONE_OE_I);
	endproperty
	a_p1: assert property (p_p1) else $error("port 1 pin");
	property p_dbg;
		DEBUG_PIN_GPIO_O == (DEBUG_DISABLE_I && !DEBUG_PIN_FAST_O)
			&& (!DEBUG_PIN_FAST_O || DEBUG_DISABLE_I && PORT2_PULLUP_EN_O[1]);
	endproperty
	a_dbg: assert property (p_dbg) else $error("debug pin");
	property p_rd;
		s_acc(RD_I, 8'h2b, 1'b0) |=> RDATA_O == {2'h0, PORT1_PWM_SEL_O};
	endproperty
	a_rd: assert property (p_rd) else $error("port 1 read");
endmodule // mfpm_monitor

bind mfpm_top mfpm_monitor u_mon (.*);

// ==== sim/mfpm_pin_model.sv ====
/* far-side sources for port 1: gpio out, gpio enable and pwm.
   assumes the system clock; the pattern starts seeded, no reset. */
`timescale 1ns/1ps
module mfpm_pin_model (
	input  wire logic       clk_i,
	output logic      [5:0] io_out_o,
	output logic      [5:0] io_oe_o,
	output logic      [5:0] pwm_o
);
	logic [17:0] lfsr = 18'h0_b5e3;
	// new pattern each edge, so a mux stuck on one source shows
	always @(posedge clk_i) begin
		lfsr <= {lfsr[16:0], lfsr[17] ^ lfsr[10]};
	end
	assign {io_out_o, io_oe_o, pwm_o} = lfsr;
endmodule // mfpm_pin_model

// ==== sim/multifunction_port_mux_tb_top.sv ====
/* self-checking bench for the port mux: writes, read-back, routing, trigger clears, option load.
   assumes mfpm_top, mfpm_pin_model and the bound checker are compiled with it. */
`timescale 1ns/1ps
module multifunction_port_mux_tb_top;
	logic       CLK_I = 1'h0, RST_I = 1'h1, WR_I = 1'h0, RD_I = 1'h0, INDIRECT_I = 1'h0;
	logic       DEBUG_DISABLE_I = 1'h0, OPTION_LOAD_I = 1'h0, ADC_CONV_START_I = 1'h0, ADC_STOP_I = 1'h0;
	logic       ADC_HW_TRIGGER_ENABLE_O, PORT2_PIN1_FAST_O, PORT2_PIN3_FAST_O, DEBUG_PIN_GPIO_O, DEBUG_PIN_FAST_O;
	logic [1:0] PORT2_UPPER_PAIR_MODE_O;
	logic [2:0] PORT0_LOW_ROUTE_O, PORT0_MID_ROUTE_O, PORT0_HIGH_ROUTE_O;
	logic [5:0] IO_BANK_ONE_OUT_I, IO_BANK_ONE_OE_I, PWM_I, PORT1_PWM_SEL_O, PORT1_PIN_OUT_O;
	logic [5:0] PORT1_PIN_OE_O, PORT2_PULLUP_EN_O;
	logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00, PORT2_MUX_OPTION_BYTE_I = 8'h00, RDATA_O, r;
	logic [8:0] ra [5] = '{9'h02a, 9'h02b, 9'h113, 9'h108, 9'h02c};
	logic [7:0] msk [5] = '{8'h3f, 8'h3f, 8'hba, 8'hbf, 8'h00};
	logic [7:0] sh [5];
	logic [2:0] lt [4] = '{3'h0, 3'h1, 3'h3, 3'h5}, mt [4] = '{3'h0, 3'h3, 3'h2, 3'h1};
	logic [2:0] ht [4] = '{3'h0, 3'h6, 3'h3, 3'h1};
	int         num_errors = 0, comparisons = 0, seed = 33354, cyc = 0, idx;
	wire logic [39:0] outs = {ADC_HW_TRIGGER_ENABLE_O, PORT0_LOW_ROUTE_O, PORT0_MID_ROUTE_O, PORT0_HIGH_ROUTE_O,
		PORT1_PWM_SEL_O, PORT2_UPPER_PAIR_MODE_O, PORT2_PIN3_FAST_O, PORT2_PIN1_FAST_O, DEBUG_PIN_GPIO_O,
		DEBUG_PIN_FAST_O, PORT2_PULLUP_EN_O, PORT1_PIN_OUT_O, PORT1_PIN_OE_O};
	mfpm_top u_dut (.*);
	mfpm_pin_model u_pins (.clk_i(CLK_I), .io_out_o(IO_BANK_ONE_OUT_I), .io_oe_o(IO_BANK_ONE_OE_I), .pwm_o(PWM_I));
	initial forever #50 CLK_I = ~CLK_I;
	//////////////////////////////
	// expected pin-side outputs from the shadow registers
	function automatic logic [39:0] expo();
		logic f;
		logic g;
		f = DEBUG_DISABLE_I & sh[2][7];
		g = DEBUG_DISABLE_I & ~sh[2][7];
		return {sh[3][7], lt[sh[0][1:0]], mt[sh[0][3:2]], ht[sh[0][5:4]], sh[1][5:0], sh[2][5:3], sh[2][1],
			g, f, ~sh[3][5:0] | {4'h0, f, 1'h0}, PWM_I & sh[1][5:0] | IO_BANK_ONE_OUT_I & ~sh[1][5:0],
			sh[1][5:0] | IO_BANK_ONE_OE_I};
	endfunction
	task automatic chk(input logic [39:0] g, e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	// optional write, then read back, then pins; reserved and unmapped bits expect zero
	task automatic acc(input int i, input logic [7:0] d, input logic w);
		{ADDR_I, INDIRECT_I, WDATA_I} <= {ra[i][7:0], ra[i][8], d};
		WR_I <= w;
		@(posedge CLK_I);
		WR_I <= 1'h0;
		RD_I <= 1'h1;
		if (w) sh[i] = d & msk[i];
		@(posedge CLK_I);
		RD_I <= 1'h0;
		@(posedge CLK_I);
		chk(RDATA_O, sh[i]);
		chk(outs, expo());
	endtask
	// one-cycle pulse: 0 conversion start, 1 stop, 2 option load
	task automatic pulse(input int k);
		{OPTION_LOAD_I, ADC_STOP_I, ADC_CONV_START_I} <= 3'h1 << k;
		@(posedge CLK_I);
		{OPTION_LOAD_I, ADC_STOP_I, ADC_CONV_START_I} <= 3'h0;
		@(posedge CLK_I);
		chk(outs, expo());
	endtask
	task automatic test_done();
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	//////////////////////////////
	// two passes, the second after a mid-run reset
	initial begin
		repeat (4) @(posedge CLK_I);
		RST_I <= 1'h0;
		for (int n = 0; n < 2; n++) begin
			sh = '{8'h00, 8'h3f, 8'hba, 8'h00, 8'h00};
			for (int i = 0; i < 5; i++) acc(i, 8'h00, 1'h0);
			for (int c = 0; c < 4; c++) begin
				// low pair code 00 also carries the comparator reference; its pad and dac setup live outside
				acc(0, {2'h0, c[1:0], c[1:0], c[1:0]}, 1'h1);
				acc(2, {c[0], 1'h0, c[1:0], 4'ha}, 1'h1);
			end
			repeat (60) begin
				DEBUG_DISABLE_I <= 1'($random(seed));
				idx = $unsigned($random(seed)) % 5;
				r = 8'($random(seed));
				if (idx == 3) r[5:0] = {{2{r[2]}}, {2{r[1]}}, {2{r[0]}}};
				// software keeps reserved bits at zero on every mux register write
				if (idx < 4) r = r & msk[idx];
				acc(idx, r, 1'h1);
			end
			for (int k = 0; k < 3; k++) begin
				acc(3, 8'h80, 1'h1);
				r = 8'($random(seed));
				PORT2_MUX_OPTION_BYTE_I <= r;
				if (k < 2) sh[3][7] = 1'h0;
				else sh[2] = r & 8'h9a;
				pulse(k);
			end
			RST_I <= 1'h1;
			repeat (4) @(posedge CLK_I);
			RST_I <= 1'h0;
		end
		test_done();
	end
	// cuts a hung run short
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			test_done();
		end
	end
endmodule // multifunction_port_mux_tb_top
